// file: logic/trace_port_defines.svh
`ifndef TRACE_PORT_DEFINES_SVH
`define TRACE_PORT_DEFINES_SVH

// register index of the port configuration register on the jtag scan path
`define CFG_INDEX 7'h7F
`define CFG_RESET 32'h00000000
// implemented bits; unsupported and reserved bits are not stored
`define CFG_WRITE_MASK 32'hFE000001

// field positions
`define CFG_FULL_BIT 31
`define CFG_GATE_BIT 30
`define CFG_EN_BIT 29
`define CFG_DIV_HI 28
`define CFG_DIV_LO 26
`define CFG_EVT_BIT 25
`define CFG_PSTAT_BIT 0

// divider codes
`define DIV_BY1 3'h0
`define DIV_BY2 3'h1
`define DIV_BY4 3'h3
`define DIV_BY8 3'h7

// jtag instruction register
`define IR_LEN 7
`define IR_CAPTURE 7'h01
`define IR_RESET 7'h00

// identification message; value is arbitrary
`define DEVICE_IDENT 32'h00005A3C
`define IDENT_BEATS_FULL 3'h2
`define IDENT_BEATS_NARROW 3'h3

// cycles after reset release before the event pin is judged
`define EVT_SETTLE 2'h3

`endif

// file: logic/trace_port_pkg.sv
package trace_port_pkg;

    // jtag tap states, one-hot
    typedef enum logic [15:0] {
        TAP_RESET = 16'h0001,
        TAP_IDLE = 16'h0002,
        TAP_SEL_DR = 16'h0004,
        TAP_CAP_DR = 16'h0008,
        TAP_SHIFT_DR = 16'h0010,
        TAP_EXIT1_DR = 16'h0020,
        TAP_PAUSE_DR = 16'h0040,
        TAP_EXIT2_DR = 16'h0080,
        TAP_UPD_DR = 16'h0100,
        TAP_SEL_IR = 16'h0200,
        TAP_CAP_IR = 16'h0400,
        TAP_SHIFT_IR = 16'h0800,
        TAP_EXIT1_IR = 16'h1000,
        TAP_PAUSE_IR = 16'h2000,
        TAP_EXIT2_IR = 16'h4000,
        TAP_UPD_IR = 16'h8000
    } tap_state_e;

endpackage

// file: logic/aux_clock_divider.sv
`timescale 1ns/1ps
`include "trace_port_defines.svh"

// makes the auxiliary output clock and the beat enable from mclk
module aux_clock_divider (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // control
    input wire logic run,
    input wire logic [2:0] ratioCode,
    // outputs
    output logic tick,
    output logic auxClk
);
    logic [2:0] count; // position within one aux period
    logic [2:0] lastCount; // period minus one
    logic phaseHigh; // registered high half for ratios 2 and up
    logic runQ; // run delayed for the undivided clock gate

    // reserved codes fall back to divide by 8, the slowest safe rate
    always_comb begin
        unique case (ratioCode)
            `DIV_BY1: lastCount = 3'h0;
            `DIV_BY2: lastCount = 3'h1;
            `DIV_BY4: lastCount = 3'h3;
            default: lastCount = 3'h7;
        endcase
    end

    // period counter, parked at the last count while stopped
    // so a gated restart opens with a beat, never a stale clock edge
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            count <= 3'h0;
        end else if (!run) begin
            count <= lastCount; // next run begins on a tick
        end else if (count == lastCount) begin
            count <= 3'h0;
        end else begin
            count <= count + 3'h1;
        end
    end

    // high half of the period: first half of the count
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            phaseHigh <= 1'b0;
            runQ <= 1'b0;
        end else begin
            runQ <= run;
            phaseHigh <= run && (lastCount != 3'h0)
                && (({1'b0, count} + 4'h1) <= {1'b0, lastCount[2:1], 1'b0} >> 1
                    || count == lastCount);
        end
    end

    // beat enable at the end of each period; when divided, data change on the same mclk edge that raises the aux clock
    assign tick = run && (count == lastCount);
    // undivided mode passes a gated, inverted mclk, otherwise the registered phase
    assign auxClk = (lastCount == 3'h0) ? (runQ & ~mclk) : phaseHigh;
endmodule

// file: logic/trace_port_config.sv
`timescale 1ns/1ps
`include "trace_port_defines.svh"

// Contract
// - configuration register overrides all client port settings
// - message bit0 high until clock is stable
// - jtag access only after bit0 goes low
// - identification message sent once port configured
// - only jtag writes configuration, never the processor
// - field layout fixed, all bits reset zero
// - width bit picks sixteen or twelve outputs
// - narrow mode gives pins 12-15 to gpio; only gpioOe is passed, gpioOut is not used and the data bits stay zero
// - divider codes one, two, four, eight
// - aux clock never above 80 MHz
// - ddr, config select, lowpower bits unsupported
// - excess trace overflows and is lost
// - event pin forces debug or breakpoints
// - compliance select low holds debug reset
// - clock gate stops clock between messages
module trace_port_config
    import trace_port_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // pins from the tool
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic jtagComplianceSelect,
    input wire logic eventInPin_n,
    // pll lock or stable clock indication
    input wire logic clockStable,
    // pin to the tool
    output logic tdo,
    output logic tdoOe,
    // message data pins
    output logic [15:0] messageDataOut,
    output logic [15:0] messageDataOe,
    output logic messageValid,
    output logic auxOutClock,
    // gpio side of pins 12 to 15
    input wire logic [3:0] gpioOut,
    input wire logic [3:0] gpioOe,
    // trace words from on-chip clients
    input wire logic [15:0] traceData,
    input wire logic traceValid,
    output logic traceReady,
    output logic traceOverflow,
    // global port settings seen by all clients
    output logic fullWidthSelect,
    output logic auxPortEnable,
    output logic eventPinEnable,
    // debug requests to the core
    output logic debugModeRequest,
    output logic breakpointRequest
);
    // pin synchronisers
    logic [1:0] tckSync;
    logic [1:0] tmsSync;
    logic [1:0] tdiSync;
    logic [1:0] compSync;
    logic [1:0] evtSync;
    logic [1:0] stableSync;
    logic tckPrev; // edge detector on the synchronised tck
    logic tckRise;
    logic tckFall;
    logic evtPrev; // previous synchronised event level

    // configuration and port state
    logic [31:0] portConfig; // the configuration register, stored bits only
    logic [2:0] auxClockDivider; // divider field
    logic auxClockGate; // gate clock between messages
    logic startupHold; // bit0 held high until the clock is stable
    logic tapHold; // tap kept in reset

    // jtag tap
    tap_state_e tapState;
    tap_state_e next_tapState;
    logic [`IR_LEN-1:0] irShift;
    logic [`IR_LEN-1:0] instruction;
    logic [31:0] drShift;
    logic bypassBit;
    logic cfgSelected; // instruction addresses the configuration register

    // message sender
    logic [2:0] identBeats; // identification beats still to send
    logic [31:0] identShift; // identification word, shifted out per beat
    logic [15:0] traceSlot; // single word holding stage
    logic slotFull;
    logic clockRun;
    logic beatTick;
    logic [1:0] settleCount; // startup delay before judging event pin
    logic evtJudged;

    // two flip-flops on every pin input
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tckSync <= 2'h0;
            tmsSync <= 2'h3;
            tdiSync <= 2'h3;
            compSync <= 2'h0;
            evtSync <= 2'h3;
            stableSync <= 2'h0;
        end else begin
            tckSync <= {tckSync[0], tck};
            tmsSync <= {tmsSync[0], tms};
            tdiSync <= {tdiSync[0], tdi};
            compSync <= {compSync[0], jtagComplianceSelect};
            evtSync <= {evtSync[0], eventInPin_n};
            stableSync <= {stableSync[0], clockStable};
        end
    end

    // tck edge detection on the second stage
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tckPrev <= 1'b0;
        end else begin
            tckPrev <= tckSync[1];
        end
    end
    assign tckRise = tckSync[1] & ~tckPrev;
    assign tckFall = ~tckSync[1] & tckPrev;

    // bit0 stays high from reset until the clock source is stable
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            startupHold <= 1'b1;
        end else if (stableSync[1]) begin
            startupHold <= 1'b0;
        end
    end

    // tap held in reset while bit0 is high or compliance select is low
    assign tapHold = startupHold || !compSync[1];

    // tap next state from tms
    always_comb begin
        next_tapState = tapState;
        unique case (tapState)
            TAP_RESET: next_tapState = tmsSync[1] ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: next_tapState = tmsSync[1] ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: next_tapState = tmsSync[1] ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: next_tapState = tmsSync[1] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: next_tapState = tmsSync[1] ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: next_tapState = tmsSync[1] ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: next_tapState = tmsSync[1] ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: next_tapState = tmsSync[1] ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: next_tapState = tmsSync[1] ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: next_tapState = tmsSync[1] ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: next_tapState = tmsSync[1] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: next_tapState = tmsSync[1] ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: next_tapState = tmsSync[1] ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: next_tapState = tmsSync[1] ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: next_tapState = tmsSync[1] ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: next_tapState = tmsSync[1] ? TAP_SEL_DR : TAP_IDLE;
            default: next_tapState = TAP_RESET; // illegal code recovers
        endcase
    end

    // tap state register, stepped on each tck rising edge
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tapState <= TAP_RESET;
        end else if (tapHold) begin
            tapState <= TAP_RESET;
        end else if (tckRise) begin
            tapState <= next_tapState;
        end
    end

    // instruction register: capture, shift, update
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irShift <= `IR_RESET;
            instruction <= `IR_RESET;
        end else if (tapState == TAP_RESET) begin
            instruction <= `IR_RESET;
        end else if (tckRise) begin
            if (tapState == TAP_CAP_IR) begin
                irShift <= `IR_CAPTURE;
            end else if (tapState == TAP_SHIFT_IR) begin
                irShift <= {tdiSync[1], irShift[`IR_LEN-1:1]};
            end else if (tapState == TAP_UPD_IR) begin
                instruction <= irShift;
            end
        end
    end
    assign cfgSelected = (instruction == `CFG_INDEX);

    // data register: config readback or bypass
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            drShift <= 32'h00000000;
            bypassBit <= 1'b0;
        end else if (tckRise) begin
            if (tapState == TAP_CAP_DR) begin
                drShift <= portConfig;
                bypassBit <= 1'b0;
            end else if (tapState == TAP_SHIFT_DR) begin
                drShift <= {tdiSync[1], drShift[31:1]};
                bypassBit <= tdiSync[1];
            end
        end
    end

    // configuration register; no processor write path exists
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            portConfig <= `CFG_RESET;
        end else if (tckRise && tapState == TAP_UPD_DR && cfgSelected) begin
            portConfig <= drShift & `CFG_WRITE_MASK;
        end
    end

    // field decode; these drive every client's port settings
    assign fullWidthSelect = portConfig[`CFG_FULL_BIT];
    assign auxPortEnable = portConfig[`CFG_EN_BIT];
    assign eventPinEnable = portConfig[`CFG_EVT_BIT];
    assign auxClockGate = portConfig[`CFG_GATE_BIT];
    assign auxClockDivider = portConfig[`CFG_DIV_HI:`CFG_DIV_LO];

    // tdo changes on the tck falling edge, driven only while shifting
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tdo <= 1'b0;
            tdoOe <= 1'b0;
        end else if (tckFall) begin
            tdoOe <= (tapState == TAP_SHIFT_DR) || (tapState == TAP_SHIFT_IR);
            if (tapState == TAP_SHIFT_IR) begin
                tdo <= irShift[0];
            end else if (cfgSelected) begin
                tdo <= drShift[0];
            end else begin
                tdo <= bypassBit;
            end
        end
    end

    // identification message armed when the port becomes enabled
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            identBeats <= 3'h0;
            identShift <= 32'h00000000;
        end else if (tckRise && tapState == TAP_UPD_DR && cfgSelected
            && !auxPortEnable && drShift[`CFG_EN_BIT]) begin
            identShift <= `DEVICE_IDENT;
            identBeats <= drShift[`CFG_FULL_BIT] ? `IDENT_BEATS_FULL : `IDENT_BEATS_NARROW;
        end else if (beatTick && identBeats != 3'h0) begin
            identBeats <= identBeats - 3'h1;
            identShift <= fullWidthSelect ? {16'h0000, identShift[31:16]}
                : {12'h000, identShift[31:12]};
        end
    end

    // one-word holding stage; a word arriving while full is dropped
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            traceSlot <= 16'h0000;
            slotFull <= 1'b0;
        end else if (traceValid && !slotFull && auxPortEnable) begin
            traceSlot <= traceData;
            slotFull <= 1'b1;
        end else if (beatTick && identBeats == 3'h0) begin
            slotFull <= 1'b0;
        end
    end
    assign traceReady = !slotFull && auxPortEnable;
    assign traceOverflow = traceValid && !traceReady;

    // clock runs while enabled; gated off when idle if the gate bit is set
    assign clockRun = auxPortEnable
        && (!auxClockGate || identBeats != 3'h0 || slotFull);

    aux_clock_divider clockDivider (
        .mclk(mclk),
        .rstn(rstn),
        .run(clockRun),
        .ratioCode(auxClockDivider),
        .tick(beatTick),
        .auxClk(auxOutClock)
    );

    // message data pins; bit0 high during startup hold
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            messageDataOut <= 16'h0001;
            messageValid <= 1'b0;
        end else if (startupHold) begin
            messageDataOut <= 16'h0001;
            messageValid <= 1'b0;
        end else if (!auxPortEnable) begin
            messageDataOut <= 16'h0000;
            messageValid <= 1'b0;
        end else if (beatTick) begin
            messageValid <= (identBeats != 3'h0) || slotFull;
            if (identBeats != 3'h0) begin
                messageDataOut <= fullWidthSelect ? identShift[15:0]
                    : {4'h0, identShift[11:0]};
            end else if (slotFull) begin
                messageDataOut <= fullWidthSelect ? traceSlot
                    : {4'h0, traceSlot[11:0]};
            end else begin
                messageDataOut <= 16'h0000;
            end
        end
    end

    // pin enables; upper four pins go to gpio in narrow mode
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            messageDataOe <= 16'h0001;
        end else if (startupHold) begin
            messageDataOe <= 16'h0001;
        end else if (!auxPortEnable) begin
            messageDataOe <= {gpioOe, 12'h000};
        end else begin
            messageDataOe <= {fullWidthSelect ? 4'hF : gpioOe, 12'hFFF};
        end
    end

    // event pin judged after reset, then watched for breakpoints
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            settleCount <= 2'h0;
            evtJudged <= 1'b0;
            evtPrev <= 1'b1;
            debugModeRequest <= 1'b0;
            breakpointRequest <= 1'b0;
        end else begin
            evtPrev <= evtSync[1];
            debugModeRequest <= 1'b0;
            if (settleCount != `EVT_SETTLE) begin
                settleCount <= settleCount + 2'h1;
            end else if (!evtJudged) begin
                evtJudged <= 1'b1;
                debugModeRequest <= compSync[1] && !evtSync[1];
            end
            breakpointRequest <= evtJudged && compSync[1] && eventPinEnable
                && evtPrev && !evtSync[1];
        end
    end
endmodule

// file: dv/trace_port_config_monitor.sv
`timescale 1ns/1ps

// watches the trace port configuration block at its pins
module trace_port_config_monitor (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // tool side
    input wire logic jtagComplianceSelect,
    input wire logic clockStable,
    input wire logic tdoOe,
    // message port
    input wire logic [15:0] messageDataOut,
    input wire logic [15:0] messageDataOe,
    input wire logic messageValid,
    input wire logic auxOutClock,
    input wire logic [3:0] gpioOe,
    input wire logic traceValid,
    input wire logic traceReady,
    input wire logic traceOverflow,
    // settings and requests
    input wire logic fullWidthSelect,
    input wire logic auxPortEnable,
    input wire logic eventPinEnable,
    input wire logic debugModeRequest,
    input wire logic breakpointRequest
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    // bit0 handshake around clock lock
    chk_bit0_hold: assert property (
        !clockStable && messageDataOut[0] |=> messageDataOut[0] && messageDataOe[0])
        else $error("bit0 dropped before clock stable");
    chk_bit0_release: assert property (
        (clockStable && !auxPortEnable && !messageValid)[*5] |-> !messageDataOut[0])
        else $error("bit0 still high after clock stable");
    // tap stays quiet while refused
    chk_tap_wait: assert property (
        (!clockStable)[*3] |-> !tdoOe)
        else $error("tap shifting before bit0 release");
    chk_tap_quiet: assert property (
        (!jtagComplianceSelect)[*3] |-> !tdoOe)
        else $error("tap shifting with compliance low");
    // pin enables follow the width setting
    chk_full_oe: assert property (
        (auxPortEnable && fullWidthSelect)[*2] |-> messageDataOe == 16'hFFFF)
        else $error("full width pins not all enabled");
    chk_narrow_oe: assert property (
        (auxPortEnable && !fullWidthSelect)[*2]
        |-> messageDataOe[11:0] == 12'hFFF && messageDataOe[15:12] == gpioOe)
        else $error("narrow width pin enables wrong");
    // client words only while the port is enabled
    chk_ready_gate: assert property (
        !auxPortEnable |-> !traceReady)
        else $error("trace ready with port disabled");
    chk_overflow_flag: assert property (
        traceOverflow == (traceValid && !traceReady))
        else $error("overflow flag mismatch");
    // a taken word fills the single slot, so the next word is refused
    chk_slot_fill: assert property (
        traceValid && traceReady |=> !traceReady)
        else $error("slot still ready after a word was taken");
    // identification word leads after enabling
    chk_ident_first: assert property (
        $rose(auxPortEnable) |-> ##[1:40] messageValid && messageDataOut[11:0] == 12'hA3C)
        else $error("identification beat missing");
    chk_aux_still: assert property (
        (!auxPortEnable)[*2] |-> !auxOutClock)
        else $error("aux clock running while disabled");
    // event pin requests
    chk_debug_pulse: assert property (
        debugModeRequest |-> jtagComplianceSelect ##1 !debugModeRequest)
        else $error("debug request malformed");
    chk_bkpt_cause: assert property (
        breakpointRequest |-> eventPinEnable && jtagComplianceSelect)
        else $error("breakpoint without enable");
endmodule

bind trace_port_config trace_port_config_monitor i_mon (.*);

// file: dv/jtag_tool_model.sv
`timescale 1ns/1ps
`include "trace_port_defines.svh"

// jtag side of the debug tool, bit-banged off mclk
module jtag_tool_model (
    // clock
    input wire logic mclk,
    // pins from the device
    input wire logic tdo,
    input wire logic bit0,
    // pins to the device
    output logic tck,
    output logic tms,
    output logic tdi
);
    // idle pins at time zero
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // one tck period, five mclk a half so the synchroniser sees each level
    task automatic step(input logic m, input logic d, output logic q);
        @(negedge mclk);
        tck = 1'b0;
        tms = m;
        tdi = d;
        repeat (5) @(negedge mclk);
        q = tdo;
        tck = 1'b1;
        repeat (4) @(negedge mclk);
    endtask

    // lsb first shift, leaves through update to idle
    task automatic shift(input int n, input logic [31:0] d, output logic [31:0] q);
        logic b;
        q = 32'h00000000;
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, d[i], b);
            q[i] = b;
        end
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask

    // no access until bit0 has dropped
    task automatic wait_ready(output bit ok);
        for (int n = 0; n < 200 && bit0 !== 1'b0; n++) begin
            @(negedge mclk);
        end
        ok = (bit0 === 1'b0);
    endtask

    // full configuration access: old value out, new value in
    task automatic cfg_access(input logic [31:0] wd, output logic [31:0] rd);
        logic b;
        logic [31:0] junk;
        repeat (5) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        // select-dr, select-ir, capture-ir, shift-ir
        step(1'b1, 1'b0, b);
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        shift(7, {25'h0, `CFG_INDEX}, junk);
        // select-dr, capture-dr, shift-dr
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        shift(32, wd, rd);
    endtask
endmodule

// file: dv/tb.sv
`timescale 1ns/1ps
`include "trace_port_defines.svh"

// self-checking bench for the trace port configuration block
module tb;
    // clock, reset and pins
    logic mclk = 1'b0;
    logic rstn;
    logic tck, tms, tdi, tdo, tdoOe;
    logic jtagComplianceSelect, eventInPin_n, clockStable;
    logic [15:0] messageDataOut, messageDataOe, traceData;
    logic messageValid, auxOutClock, traceValid, traceReady, traceOverflow;
    logic [3:0] gpioOut = 4'hA;
    logic [3:0] gpioOe = 4'h5;
    logic fullWidthSelect, auxPortEnable, eventPinEnable;
    logic debugModeRequest, breakpointRequest;
    // bookkeeping
    int errTotal = 0;
    int compares = 0;
    int cycles = 0;
    int auxRises = 0;
    int dbgSeen = 0;
    int bkptSeen = 0;
    int ovfSeen = 0;
    int n;
    bit ok;
    logic [31:0] rd, cfgNow;
    logic [15:0] beats[$];
    localparam logic [31:0] IDENT = `DEVICE_IDENT;
    logic [2:0] divCode[5] = '{`DIV_BY1, `DIV_BY2, `DIV_BY4, `DIV_BY8, 3'h2};
    int divRises[5] = '{80, 40, 20, 10, 10};
    logic [15:0] words[3] = '{16'h1230, 16'h4560, 16'h7890};

    always #12.5 mclk = ~mclk;

    trace_port_config i_dut (.*);

    jtag_tool_model i_tool (.mclk(mclk), .tdo(tdo), .bit0(messageDataOut[0]),
        .tck(tck), .tms(tms), .tdi(tdi));

    // pulse counters
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (debugModeRequest === 1'b1) dbgSeen <= dbgSeen + 1;
        if (breakpointRequest === 1'b1) bkptSeen <= bkptSeen + 1;
        if (traceOverflow === 1'b1) ovfSeen <= ovfSeen + 1;
    end
    // aux clock edges and beats seen by the tool
    always @(posedge auxOutClock) auxRises++;
    always @(negedge auxOutClock) if (messageValid === 1'b1) beats.push_back(messageDataOut);

    // cut a hung run short
    always @(negedge mclk) begin
        if (cycles == 30000) begin
            errTotal++;
            closeOut();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errTotal++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // write a new setting, read back the previous one
    task automatic cfg(input logic [31:0] wd);
        i_tool.cfg_access(wd, rd);
        check(rd, cfgNow);
        cfgNow = wd & `CFG_WRITE_MASK;
    endtask

    // identification beats of w bits each
    task automatic ident(input int w, input int cnt);
        logic [31:0] m;
        m = (32'h1 << w) - 32'h1;
        repeat (80) @(negedge mclk);
        check(beats.size(), cnt);
        foreach (beats[i]) check({16'h0, beats[i]} & m, (IDENT >> (w * i)) & m);
    endtask

    task automatic closeOut();
        $display("compares=%0d errors=%0d", compares, errTotal);
        if (errTotal == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        rstn = 1'b0;
        jtagComplianceSelect = 1'b1;
        eventInPin_n = 1'b1;
        clockStable = 1'b0;
        traceData = 16'h0000;
        traceValid = 1'b0;
        cfgNow = `CFG_RESET;
        repeat (6) @(negedge mclk);
        rstn = 1'b1;
        repeat (20) @(negedge mclk);
        check({messageDataOe[0], messageDataOut[0]}, 2'b11);
        clockStable = 1'b1;
        i_tool.wait_ready(ok);
        check(ok, 1'b1);
        // reset value, then every bit written but the status bit
        cfg(32'h00000000);
        beats.delete();
        cfg(32'hFFFFFFFE);
        ident(16, 2);
        check({fullWidthSelect, auxPortEnable, eventPinEnable}, 3'h7);
        // event pin falls with event enable set
        eventInPin_n = 1'b0;
        repeat (10) @(negedge mclk);
        eventInPin_n = 1'b1;
        check(bkptSeen, 1);
        check(dbgSeen, 0);
        cfg(32'h00000000);
        beats.delete();
        cfg(32'h2C000000);
        ident(12, 3);
        // each defined divider code and reserved code 2, disabled while changed
        foreach (divCode[k]) begin
            cfg(32'h00000000);
            cfg(32'hA0000000 | (32'(divCode[k]) << 26));
            repeat (100) @(negedge mclk);
            n = auxRises;
            repeat (80) @(negedge mclk);
            check(auxRises - n, divRises[k]);
        end
        // gated clock, then three words back to back
        cfg(32'h00000000);
        cfg(32'hFC000000);
        repeat (80) @(negedge mclk);
        n = auxRises;
        repeat (40) @(negedge mclk);
        check(auxRises - n, 0);
        beats.delete();
        n = ovfSeen;
        traceValid = 1'b1;
        foreach (words[k]) begin
            traceData = words[k];
            @(negedge mclk);
        end
        traceValid = 1'b0;
        repeat (60) @(negedge mclk);
        check(beats.size() + ovfSeen - n, 3);
        check(ovfSeen > n, 1'b1);
        check(beats[0], words[0]);
        // access with compliance low is ignored
        jtagComplianceSelect = 1'b0;
        i_tool.cfg_access(32'h00000000, rd);
        jtagComplianceSelect = 1'b1;
        cfg(32'hFC000000);
        // reset with the event pin low forces debug
        eventInPin_n = 1'b0;
        rstn = 1'b0;
        repeat (6) @(negedge mclk);
        rstn = 1'b1;
        repeat (20) @(negedge mclk);
        check(dbgSeen, 1);
        check(auxPortEnable, 1'b0);
        closeOut();
    end
endmodule
